// *** hw/tlic_pkg.sv ***
// Constants and carrier types for the two-level interrupt controller.
// Assumes a single core clock domain; all users reference names with tlic_pkg::.
package tlic_pkg;

  // Special function register addresses
  localparam logic [7:0] PRIMARY_ENABLE_ADDR   = 8'ha8;
  localparam logic [7:0] PRIMARY_PRIORITY_ADDR = 8'hb8;
  localparam logic [7:0] SECONDARY_CTRL_ADDR   = 8'ha9;

  // Reset values and the unmapped read value
  localparam logic [7:0] PRIMARY_ENABLE_RESET   = 8'h00;
  localparam logic [7:0] PRIMARY_PRIORITY_RESET = 8'h00;
  localparam logic [7:0] SECONDARY_CTRL_RESET   = 8'ha0;
  localparam logic [7:0] UNMAPPED_READ          = 8'h00;

  // Primary enable and priority register fields
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int ADC_BIT               = 6;
  localparam int TIMER2_BIT            = 5;
  localparam int UART_BIT              = 4;
  localparam int TIMER1_BIT            = 3;
  localparam int EXT1_BIT              = 2;
  localparam int TIMER0_BIT            = 1;
  localparam int EXT0_BIT              = 0;
  localparam int PRIMARY_RESERVED_BIT  = 7;

  // Secondary control register fields
  localparam int SECONDARY_RESERVED_BIT      = 7;
  localparam int INTERVAL_COUNTER_PRIO_BIT   = 6;
  localparam int SUPPLY_MONITOR_PRIO_BIT     = 5;
  localparam int SPI_PRIO_BIT                = 4;
  localparam int SECONDARY_MUST_ZERO_BIT     = 3;
  localparam int INTERVAL_COUNTER_ENABLE_BIT = 2;
  localparam int SUPPLY_MONITOR_ENABLE_BIT   = 1;
  localparam int SPI_ENABLE_BIT              = 0;

  // Polling order: index 0 wins within a level
  localparam int SRC_COUNT            = 11;
  localparam int SRC_SUPPLY_MONITOR   = 0;
  localparam int SRC_WATCHDOG         = 1;
  localparam int SRC_EXT0             = 2;
  localparam int SRC_ADC              = 3;
  localparam int SRC_TIMER0           = 4;
  localparam int SRC_EXT1             = 5;
  localparam int SRC_TIMER1           = 6;
  localparam int SRC_SPI              = 7;
  localparam int SRC_UART             = 8;
  localparam int SRC_TIMER2           = 9;
  localparam int SRC_INTERVAL_COUNTER = 10;

  // Vector addresses
  localparam logic [15:0] VEC_EXT0             = 16'h0003;
  localparam logic [15:0] VEC_TIMER0           = 16'h000b;
  localparam logic [15:0] VEC_EXT1             = 16'h0013;
  localparam logic [15:0] VEC_TIMER1           = 16'h001b;
  localparam logic [15:0] VEC_UART             = 16'h0023;
  localparam logic [15:0] VEC_TIMER2           = 16'h002b;
  localparam logic [15:0] VEC_ADC              = 16'h0033;
  localparam logic [15:0] VEC_SPI              = 16'h003b;
  localparam logic [15:0] VEC_SUPPLY_MONITOR   = 16'h0043;
  localparam logic [15:0] VEC_INTERVAL_COUNTER = 16'h0053;
  localparam logic [15:0] VEC_WATCHDOG         = 16'h005b;

  // Request levels from the peripherals, one field per source
  typedef struct packed {
    logic intervalCounterRequest;
    logic timer2Flags;
    logic uartFlags;
    logic spiRequest;
    logic timer1Overflow;
    logic ext1Request;
    logic timer0Overflow;
    logic adcDoneRequest;
    logic ext0Request;
    logic watchdogRequest;
    logic supplyMonitorRequest;
  } tlic_req_type;

  // Register bus request from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wrData;
  } tlic_sfr_type;

  // Dispatch offered to the core
  typedef struct packed {
    logic        valid;
    logic        high;
    logic [15:0] vector;
  } tlic_offer_type;

endpackage : tlic_pkg

// *** hw/tlic_pick.sv ***
// Fixed-order picker: lowest set index wins.
// Assumes index 0 is the highest position in the polling order.
`timescale 1ns/1ps
`default_nettype none
module tlic_pick (
  input  wire logic [10:0] req,
  output var  logic        found,
  output var  logic [3:0]  idx
);

  always_comb begin
    found = 1'b0;
    idx   = 4'h0;
    for (int i = 10; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = 4'(i);
      end
    end
  end

endmodule : tlic_pick
`default_nettype wire

// *** hw/tlic_vector.sv ***
// Source index to vector address lookup.
// Assumes the index follows the polling order held in the package.
`timescale 1ns/1ps
`default_nettype none
module tlic_vector (
  input  wire logic [3:0]  idx,
  output var  logic [15:0] vector
);

  always_comb begin
    case (idx)
      4'(tlic_pkg::SRC_SUPPLY_MONITOR):   vector = tlic_pkg::VEC_SUPPLY_MONITOR;
      4'(tlic_pkg::SRC_WATCHDOG):         vector = tlic_pkg::VEC_WATCHDOG;
      4'(tlic_pkg::SRC_EXT0):             vector = tlic_pkg::VEC_EXT0;
      4'(tlic_pkg::SRC_ADC):              vector = tlic_pkg::VEC_ADC;
      4'(tlic_pkg::SRC_TIMER0):           vector = tlic_pkg::VEC_TIMER0;
      4'(tlic_pkg::SRC_EXT1):             vector = tlic_pkg::VEC_EXT1;
      4'(tlic_pkg::SRC_TIMER1):           vector = tlic_pkg::VEC_TIMER1;
      4'(tlic_pkg::SRC_SPI):              vector = tlic_pkg::VEC_SPI;
      4'(tlic_pkg::SRC_UART):             vector = tlic_pkg::VEC_UART;
      4'(tlic_pkg::SRC_TIMER2):           vector = tlic_pkg::VEC_TIMER2;
      4'(tlic_pkg::SRC_INTERVAL_COUNTER): vector = tlic_pkg::VEC_INTERVAL_COUNTER;
      default:                            vector = 16'h0000;
    endcase
  end

endmodule : tlic_vector
`default_nettype wire

// *** hw/tlic_top.sv ***
// Two-level interrupt controller: enable and priority registers, level
// arbitration, in-service tracking and vector supply to the core.
// Assumes request levels come from same-clock peripherals and stay high until
// the handler clears them; the core acknowledges a dispatch and signals return.
//
// Function
// (R1) Secondary bit 6: interval counter priority.
// (R2) Secondary bit 5: supply monitor priority.
// (R3) Secondary bit 4: SPI priority.
// (R4) Software keeps bit 3 zero; bit 7 reserved.
// (R5) Secondary bit 2: interval counter enable.
// (R6) Secondary bit 1: supply monitor enable.
// (R7) Secondary bit 0: SPI enable.
// (R8) High request preempts low handler.
// (R9) Simultaneous different levels: high first.
// (R10) No same-level dispatch while level in service.
// (R11) Fixed polling order within a level.
// (R12) Core pushes PC; controller supplies vector.
// (R13) Vectors for external, timer, UART sources.
// (R14) Vectors for ADC, SPI, monitor, interval counter.
// (R15) Watchdog interrupt when select set, vector 005BH.
// (R16) Watchdog always high priority.
// (R17) Global enable never masks watchdog.
// (R18) Watchdog interrupts only with nonzero timeout.
// (R19) Primary bit 7 is global enable.
// (R20) Primary bits 6..0 enable seven sources.
// (R21) Priority bits 6..0 set seven priorities.
// (R22) Return clears in-service marker of level; code ignores a return that comes in the same cycle as irqAck on a valid offer.
// (R23) Dispatch needs flag, enable and global enable.
`timescale 1ns/1ps
`default_nettype none
module tlic_top (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire tlic_pkg::tlic_sfr_type sfrReq,
  output var  logic [7:0]             sfrRdData,
  input  wire tlic_pkg::tlic_req_type srcReq,
  input  wire logic                   watchdogIrqSelect,
  input  wire logic                   watchdogTimeoutNonzero,
  output var  logic                   irqValid,
  output var  logic                   irqHigh,
  output var  logic [15:0]            irqVector,
  input  wire logic                   irqAck,
  input  wire logic                   irqReturn,
  output var  logic                   inServiceHigh,
  output var  logic                   inServiceLow
);

  typedef struct packed {
    logic [7:0]               primaryEnableReg;
    logic [7:0]               primaryPriorityReg;
    logic [7:0]               secondaryIrqCtrl;
    logic [7:0]               rdData;
    logic                     svcHigh;
    logic                     svcLow;
    tlic_pkg::tlic_offer_type offer;
  } tlic_state_type;

  localparam tlic_state_type STATE_RESET = '{
    primaryEnableReg:   tlic_pkg::PRIMARY_ENABLE_RESET,
    primaryPriorityReg: tlic_pkg::PRIMARY_PRIORITY_RESET,
    secondaryIrqCtrl:   tlic_pkg::SECONDARY_CTRL_RESET,
    rdData:             8'h00,
    svcHigh:            1'b0,
    svcLow:             1'b0,
    offer:              '{valid: 1'b0, high: 1'b0, vector: 16'h0000}
  };

  tlic_state_type state;
  tlic_state_type next_state;

  logic [10:0] reqVec;
  logic [10:0] enableVec;
  logic [10:0] highVec;
  logic [10:0] pendHigh;
  logic [10:0] pendLow;
  logic        foundHigh;
  logic        foundLow;
  logic [3:0]  idxHigh;
  logic [3:0]  idxLow;
  logic [3:0]  idxSel;
  logic [15:0] vectorSel;
  logic        globalOn;

  assign reqVec = {srcReq.intervalCounterRequest, srcReq.timer2Flags, srcReq.uartFlags,
                   srcReq.spiRequest, srcReq.timer1Overflow, srcReq.ext1Request,
                   srcReq.timer0Overflow, srcReq.adcDoneRequest, srcReq.ext0Request,
                   srcReq.watchdogRequest, srcReq.supplyMonitorRequest};

  // (R19) global enable bit
  assign globalOn = state.primaryEnableReg[tlic_pkg::GLOBAL_IRQ_ENABLE_BIT];

  always_comb begin
    enableVec = 11'h000;
    highVec   = 11'h000;
    // (R20) primary enable bits
    enableVec[tlic_pkg::SRC_ADC]    = state.primaryEnableReg[tlic_pkg::ADC_BIT];
    enableVec[tlic_pkg::SRC_TIMER2] = state.primaryEnableReg[tlic_pkg::TIMER2_BIT];
    enableVec[tlic_pkg::SRC_UART]   = state.primaryEnableReg[tlic_pkg::UART_BIT];
    enableVec[tlic_pkg::SRC_TIMER1] = state.primaryEnableReg[tlic_pkg::TIMER1_BIT];
    enableVec[tlic_pkg::SRC_EXT1]   = state.primaryEnableReg[tlic_pkg::EXT1_BIT];
    enableVec[tlic_pkg::SRC_TIMER0] = state.primaryEnableReg[tlic_pkg::TIMER0_BIT];
    enableVec[tlic_pkg::SRC_EXT0]   = state.primaryEnableReg[tlic_pkg::EXT0_BIT];
    // (R5) interval counter enable
    enableVec[tlic_pkg::SRC_INTERVAL_COUNTER] =
      state.secondaryIrqCtrl[tlic_pkg::INTERVAL_COUNTER_ENABLE_BIT];
    // (R6) supply monitor enable
    enableVec[tlic_pkg::SRC_SUPPLY_MONITOR] =
      state.secondaryIrqCtrl[tlic_pkg::SUPPLY_MONITOR_ENABLE_BIT];
    // (R7) SPI enable
    enableVec[tlic_pkg::SRC_SPI] = state.secondaryIrqCtrl[tlic_pkg::SPI_ENABLE_BIT];
    // (R23) maskable sources also need global enable
    enableVec = enableVec & {11{globalOn}};
    // (R15) watchdog as interrupt only when selected
    // (R17) global enable ignored for watchdog
    // (R18) nonzero timeout required
    enableVec[tlic_pkg::SRC_WATCHDOG] = watchdogIrqSelect & watchdogTimeoutNonzero;

    // (R21) primary priority bits
    highVec[tlic_pkg::SRC_ADC]    = state.primaryPriorityReg[tlic_pkg::ADC_BIT];
    highVec[tlic_pkg::SRC_TIMER2] = state.primaryPriorityReg[tlic_pkg::TIMER2_BIT];
    highVec[tlic_pkg::SRC_UART]   = state.primaryPriorityReg[tlic_pkg::UART_BIT];
    highVec[tlic_pkg::SRC_TIMER1] = state.primaryPriorityReg[tlic_pkg::TIMER1_BIT];
    highVec[tlic_pkg::SRC_EXT1]   = state.primaryPriorityReg[tlic_pkg::EXT1_BIT];
    highVec[tlic_pkg::SRC_TIMER0] = state.primaryPriorityReg[tlic_pkg::TIMER0_BIT];
    highVec[tlic_pkg::SRC_EXT0]   = state.primaryPriorityReg[tlic_pkg::EXT0_BIT];
    // (R1) interval counter priority
    highVec[tlic_pkg::SRC_INTERVAL_COUNTER] =
      state.secondaryIrqCtrl[tlic_pkg::INTERVAL_COUNTER_PRIO_BIT];
    // (R2) supply monitor priority
    highVec[tlic_pkg::SRC_SUPPLY_MONITOR] =
      state.secondaryIrqCtrl[tlic_pkg::SUPPLY_MONITOR_PRIO_BIT];
    // (R3) SPI priority
    highVec[tlic_pkg::SRC_SPI] = state.secondaryIrqCtrl[tlic_pkg::SPI_PRIO_BIT];
    // (R16) watchdog fixed high
    highVec[tlic_pkg::SRC_WATCHDOG] = 1'b1;
  end

  assign pendHigh = reqVec & enableVec & highVec;
  assign pendLow  = reqVec & enableVec & ~highVec;

  // (R11) fixed polling order per level
  tlic_pick u_pick_high (
    .req   (pendHigh),
    .found (foundHigh),
    .idx   (idxHigh)
  );

  tlic_pick u_pick_low (
    .req   (pendLow),
    .found (foundLow),
    .idx   (idxLow)
  );

  // (R9) high level chosen over low
  assign idxSel = foundHigh ? idxHigh : idxLow;

  // (R13) (R14) vector lookup
  tlic_vector u_vector (
    .idx    (idxSel),
    .vector (vectorSel)
  );

  always_comb begin
    next_state = state;

    // Register writes; read data is registered one cycle after the strobe
    if (sfrReq.wr) begin
      case (sfrReq.addr)
        tlic_pkg::PRIMARY_ENABLE_ADDR: begin
          next_state.primaryEnableReg = sfrReq.wrData;
        end
        tlic_pkg::PRIMARY_PRIORITY_ADDR: begin
          next_state.primaryPriorityReg = sfrReq.wrData;
          next_state.primaryPriorityReg[tlic_pkg::PRIMARY_RESERVED_BIT] = 1'b0;
        end
        tlic_pkg::SECONDARY_CTRL_ADDR: begin
          // (R4) reserved top bit keeps its reset value; bit 3 stored as written
          next_state.secondaryIrqCtrl = sfrReq.wrData;
          next_state.secondaryIrqCtrl[tlic_pkg::SECONDARY_RESERVED_BIT] =
            tlic_pkg::SECONDARY_CTRL_RESET[tlic_pkg::SECONDARY_RESERVED_BIT];
        end
        default: begin
        end
      endcase
    end

    if (sfrReq.rd) begin
      case (sfrReq.addr)
        tlic_pkg::PRIMARY_ENABLE_ADDR:   next_state.rdData = state.primaryEnableReg;
        tlic_pkg::PRIMARY_PRIORITY_ADDR: next_state.rdData = state.primaryPriorityReg;
        tlic_pkg::SECONDARY_CTRL_ADDR:   next_state.rdData = state.secondaryIrqCtrl;
        default:                         next_state.rdData = tlic_pkg::UNMAPPED_READ;
      endcase
    end

    // (R12) taken by the core: the serviced level becomes busy
    if (irqAck && state.offer.valid) begin
      if (state.offer.high) begin
        next_state.svcHigh = 1'b1;
      end else begin
        next_state.svcLow = 1'b1;
      end
    end else if (irqReturn) begin
      // (R22) return frees the innermost level
      if (state.svcHigh) begin
        next_state.svcHigh = 1'b0;
      end else begin
        next_state.svcLow = 1'b0;
      end
    end

    // Offer is rebuilt every cycle, so a dropped request withdraws it and a
    // newly arrived high request replaces a pending low one before the ack.
    next_state.offer.valid  = 1'b0;
    next_state.offer.high   = 1'b0;
    next_state.offer.vector = state.offer.vector;
    if (!(irqAck && state.offer.valid)) begin
      // (R8) high may enter over a low handler
      // (R10) no dispatch within a busy level
      if (foundHigh && !next_state.svcHigh) begin
        next_state.offer.valid  = 1'b1;
        next_state.offer.high   = 1'b1;
        next_state.offer.vector = vectorSel;
      end else if (foundLow && !next_state.svcHigh && !next_state.svcLow) begin
        next_state.offer.valid  = 1'b1;
        next_state.offer.vector = vectorSel;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign sfrRdData     = state.rdData;
  assign irqValid      = state.offer.valid;
  assign irqHigh       = state.offer.high;
  assign irqVector     = state.offer.vector;
  assign inServiceHigh = state.svcHigh;
  assign inServiceLow  = state.svcLow;

endmodule : tlic_top
`default_nettype wire

// *** dv/tlic_core_model.sv ***
// Core-side model: takes offered dispatches after a set wait.
// Assumes the testbench drives handler returns itself.
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        irqValid,
  input  wire logic        irqHigh,
  input  wire logic [15:0] irqVector,
  input  wire logic [3:0]  ackDelay,
  output var  logic        irqAck,
  output var  logic [15:0] pc,
  output var  logic        tookHigh,
  output var  logic [7:0]  ackCount
);
  logic [3:0] waitCnt;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqAck   <= 1'b0;
      waitCnt  <= 4'h0;
      pc       <= 16'h0000;
      tookHigh <= 1'b0;
      ackCount <= 8'h00;
    end else if (irqAck) begin
      irqAck   <= #1 1'b0;
      pc       <= irqVector;
      tookHigh <= irqHigh;
      ackCount <= ackCount + 8'h01;
    end else if (irqValid && waitCnt == ackDelay) begin
      irqAck  <= #1 1'b1;
      waitCnt <= 4'h0;
    end else if (irqValid) begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : tlic_core_model
`default_nettype wire

// *** dv/tlic_properties.sv ***
// Checker on the controller's top-level ports.
// Assumes one clock domain; bound to tlic_top below.
`timescale 1ns/1ps
`default_nettype none
module tlic_properties (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire tlic_pkg::tlic_sfr_type sfrReq,
  input wire logic [7:0]             sfrRdData,
  input wire tlic_pkg::tlic_req_type srcReq,
  input wire logic                   watchdogIrqSelect,
  input wire logic                   watchdogTimeoutNonzero,
  input wire logic                   irqValid,
  input wire logic                   irqHigh,
  input wire logic [15:0]            irqVector,
  input wire logic                   irqAck,
  input wire logic                   irqReturn,
  input wire logic                   inServiceHigh,
  input wire logic                   inServiceLow
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_take;
    irqValid && irqAck;
  endsequence
  sequence s_wd_offer;
    irqValid && irqVector == tlic_pkg::VEC_WATCHDOG;
  endsequence

  property p_high_free;
    irqValid && irqHigh |-> !inServiceHigh;
  endproperty
  property p_low_free;
    irqValid && !irqHigh |-> !inServiceHigh && !inServiceLow;
  endproperty
  property p_take_high;
    s_take ##0 irqHigh |=> inServiceHigh && !irqValid;
  endproperty
  property p_take_low;
    s_take ##0 !irqHigh |=> inServiceLow && !irqValid;
  endproperty
  property p_ret_high;
    irqReturn && !irqAck && inServiceHigh |=> !inServiceHigh && $stable(inServiceLow);
  endproperty
  property p_ret_low;
    irqReturn && !irqAck && !inServiceHigh && inServiceLow |=> !inServiceLow;
  endproperty
  property p_wd_high;
    s_wd_offer |-> irqHigh;
  endproperty
  property p_wd_gate;
    s_wd_offer |-> $past(watchdogIrqSelect) && $past(watchdogTimeoutNonzero);
  endproperty
  property p_idle;
    srcReq == '0 |=> !irqValid;
  endproperty

  a_high_free: assert property (p_high_free)
    else $error("high offer while high level in service");
  a_low_free: assert property (p_low_free)
    else $error("low offer while a level is in service");
  a_take_high: assert property (p_take_high)
    else $error("high take did not mark service");
  a_take_low: assert property (p_take_low)
    else $error("low take did not mark service");
  a_ret_high: assert property (p_ret_high)
    else $error("return did not clear high marker");
  a_ret_low: assert property (p_ret_low)
    else $error("return did not clear low marker");
  a_wd_high: assert property (p_wd_high)
    else $error("watchdog offered at low level");
  a_wd_gate: assert property (p_wd_gate)
    else $error("watchdog offered without select and timeout");
  a_idle: assert property (p_idle)
    else $error("offer with no request");
endmodule : tlic_properties

bind tlic_top tlic_properties u_tlic_properties (
  .clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
  .srcReq(srcReq), .watchdogIrqSelect(watchdogIrqSelect),
  .watchdogTimeoutNonzero(watchdogTimeoutNonzero), .irqValid(irqValid),
  .irqHigh(irqHigh), .irqVector(irqVector), .irqAck(irqAck),
  .irqReturn(irqReturn), .inServiceHigh(inServiceHigh), .inServiceLow(inServiceLow)
);
`default_nettype wire

// *** dv/two_level_interrupt_controller_tb.sv ***
// Self-checking bench: register access, dispatch order, masking, preemption.
// Assumes tlic_top with the core model taking dispatches.
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_controller_tb;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  tlic_pkg::tlic_sfr_type sfr = '0;
  logic [10:0]            src = 11'h000;
  logic                   wdSel = 1'b0;
  logic                   wdNz = 1'b0;
  logic                   irqRet = 1'b0;
  logic [3:0]             ackDelay = 4'h0;
  logic                   irqValid, irqHigh, irqAck, svcHigh, svcLow, tookHigh;
  logic [7:0]             rdData, ackCount;
  logic [15:0]            irqVector, pc;
  int                     n_mismatch = 0;
  int                     comparisons = 0;
  // Vectors in polling order
  logic [15:0] vec [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b,
                           16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
  // Source behind each priority bit: B8 bits 0..6, then A9 bits 4..6
  int prSrc [10] = '{2, 4, 5, 6, 8, 9, 3, 7, 0, 10};

  always #5 clk = ~clk;

  tlic_top DUT (
    .clk(clk), .rst_n(rst_n), .sfrReq(sfr), .sfrRdData(rdData), .srcReq(src),
    .watchdogIrqSelect(wdSel), .watchdogTimeoutNonzero(wdNz), .irqValid(irqValid),
    .irqHigh(irqHigh), .irqVector(irqVector), .irqAck(irqAck), .irqReturn(irqRet),
    .inServiceHigh(svcHigh), .inServiceLow(svcLow)
  );
  tlic_core_model u_core (
    .clk(clk), .rst_n(rst_n), .irqValid(irqValid), .irqHigh(irqHigh),
    .irqVector(irqVector), .ackDelay(ackDelay), .irqAck(irqAck), .pc(pc),
    .tookHigh(tookHigh), .ackCount(ackCount)
  );

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfr = '{1'b1, 1'b0, a, d};
    @(posedge clk);
    #1 sfr = '0;
  endtask : wrReg

  task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 sfr = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    #1 sfr = '0;
    chk(16'(rdData), 16'(exp));
  endtask : rdReg

  // Waits for the core to take a dispatch, then checks what it loaded
  task automatic takeIrq(input logic [15:0] v, input logic h);
    logic [7:0] c0;
    c0 = ackCount;
    for (int i = 0; i < 40 && ackCount == c0; i++) begin
      @(posedge clk);
      #1;
    end
    if (ackCount == c0) begin
      n_mismatch++;
      $display("[ERR] %0t: no dispatch taken", $time);
      end_of_test();
    end else begin
      chk(pc, v);
      chk(16'(tookHigh), 16'(h));
    end
  endtask : takeIrq

  task automatic ret;
    @(posedge clk);
    #1 irqRet = 1'b1;
    @(posedge clk);
    #1 irqRet = 1'b0;
  endtask : ret

  // An offer that the core takes at once would drop irqValid again, so the
  // take count is compared as well
  task automatic quiet;
    logic [7:0] c0;
    c0 = ackCount;
    repeat (6) @(posedge clk);
    #1;
    chk(16'(irqValid), 16'h0000);
    chk(16'(ackCount), 16'(c0));
  endtask : quiet

  initial begin
    int k;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    rdReg(8'ha8, 8'h00);
    rdReg(8'hb8, 8'h00);
    rdReg(8'ha9, 8'ha0);
    rdReg(8'h55, 8'h00);
    // Unmapped write must leave the enable register at A8 alone
    wrReg(8'h55, 8'hff);
    rdReg(8'ha8, 8'h00);
    wrReg(8'hb8, 8'hff);
    rdReg(8'hb8, 8'h7f);
    wrReg(8'hb8, 8'h00);
    wrReg(8'ha9, 8'h00);
    rdReg(8'ha9, 8'h80);
    $display("test registers done");
    // Everything pending at once: watchdog high, the rest low
    wdSel = 1'b1;
    wdNz = 1'b1;
    wrReg(8'ha8, 8'hff);
    wrReg(8'ha9, 8'h07);
    src = 11'h7ff;
    for (int i = 0; i < 11; i++) begin
      k = (i < 2) ? 1 - i : i;
      takeIrq(vec[k], k == 1);
      src[k] = 1'b0;
      ret();
    end
    $display("test order done");
    wrReg(8'ha8, 8'h7f);
    src = 11'h007;
    takeIrq(16'h005b, 1'b1);
    src = 11'h005;
    ret();
    quiet();
    src = 11'h002;
    wdSel = 1'b0;
    quiet();
    wdSel = 1'b1;
    wdNz = 1'b0;
    quiet();
    wrReg(8'ha8, 8'hfe);
    wrReg(8'ha9, 8'h05);
    src = 11'h005;
    quiet();
    src = 11'h000;
    $display("test masking done");
    ackDelay = 4'h3;
    wrReg(8'ha8, 8'hff);
    for (int i = 0; i < 10; i++) begin
      wrReg(8'hb8, i < 7 ? 8'(8'h01 << i) : 8'h00);
      wrReg(8'ha9, i < 7 ? 8'h07 : 8'(8'h07 | (8'h10 << (i - 7))));
      src[prSrc[i]] = 1'b1;
      takeIrq(vec[prSrc[i]], 1'b1);
      src = 11'h000;
      ret();
    end
    $display("test priority done");
    ackDelay = 4'h0;
    wrReg(8'hb8, 8'h00);
    wrReg(8'ha9, 8'h47);
    src = 11'h004;
    takeIrq(16'h0003, 1'b0);
    src = 11'h014;
    quiet();
    src = 11'h414;
    takeIrq(16'h0053, 1'b1);
    chk(16'({svcHigh, svcLow}), 16'h0003);
    src = 11'h010;
    ret();
    chk(16'({svcHigh, svcLow}), 16'h0001);
    ret();
    takeIrq(16'h000b, 1'b0);
    src = 11'h000;
    ret();
    $display("test preemption done");
    end_of_test();
  end
endmodule : two_level_interrupt_controller_tb
`default_nettype wire
